// ===== verilog/ecl_regs.svh
// Purpose: constants of the configuration loader
// Assumes: included by bare name
// Notes: definitions only
`ifndef ECL_REGS_SVH
`define ECL_REGS_SVH
`define ECL_NREG 196
`define ECL_CTRL_ADDR 8'hC3
`define ECL_LAST_ADDR 8'hC7
`define ECL_SIO_ADDR 8'hA1
`define ECL_STAT_ADDR 8'hD0
`define ECL_MASK_ADDR 8'hD1
`define ECL_STATE_ADDR 8'hD2
`define ECL_SIO_CLK_BIT 0
`define ECL_SIO_DATA_BIT 1
`define ECL_CTRL_START_BIT 0
`define ECL_CTRL_RESET_BIT 1
`define ECL_CTRL_LOAD_BIT 2
`define ECL_CTRL_DFLT 8'h00
`define ECL_SIO_DFLT 8'h03
`define ECL_DFLT_BYTE 8'h00
`define ECL_EV_DONE_BIT 0
`define ECL_EV_CRCFAIL_BIT 1
`define ECL_EV_ABSENT_BIT 2
`define ECL_DEV_TYPE 4'hA
`define ECL_CHIP_ADDR 3'h0
`define ECL_CRC_INIT 32'hFFFFFFFF
`define ECL_CRC_POLY_REF 32'hEDB88320
`define ECL_CLK_PERIOD_NS 50
`define ECL_SCL_QUARTER_NS 2500
`define ECL_QUARTER_CYC \
    ((`ECL_SCL_QUARTER_NS + `ECL_CLK_PERIOD_NS - 1) / `ECL_CLK_PERIOD_NS)
`endif

// ===== verilog/ecl_pkg.sv
// Purpose: types of the configuration loader
// Assumes: nothing
// Notes: constants live in ecl_regs.svh
`default_nettype none
package ecl_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_PRES, ST_STA, ST_TXBIT, ST_TXACK,
        ST_RXBIT, ST_RXACK, ST_STO, ST_FINISH
    } ecl_state_e;
endpackage
`default_nettype wire

// ===== verilog/ecl_loader.sv
// Purpose: loads the register image from a two-wire EEPROM with CRC check
// Assumes: open-drain data pin with external pullup, serial clock driven
// Notes: host bit-bangs the EEPROM through the serial register when idle
`timescale 1ns/10ps
`default_nettype none
`include "ecl_regs.svh"

// Function
// - copy image bytes to matching register addresses
// - no host register operations during download
// - ignore reload and reset bits while loading
// - clear reload bit when download ends
// - control register written last
// - no EEPROM: skip download, defaults, halted
// - bytes shifted most significant bit first
// - only bytes zero to control are image
// - stored CRC follows image, compared
// - CRC mismatch restores defaults and halts
// - start bit resumes after halt
// - Ethernet CRC-32 generator
// - CRC over bytes in ascending order
// - 256 byte EEPROM supported
// - slave address 1010 then chip 000
// - read/write bit one for reads
module ecl_loader #(
    parameter int QUARTER_CYCLES = `ECL_QUARTER_CYC
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic clkEn, // freezes all state when low
    input wire logic [7:0] regAddr, // register address
    input wire logic [7:0] regWrData, // register write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [7:0] regRdData, // read data, cycle after strobe
    output logic eeSclOut, // serial clock to EEPROM
    input wire logic eeSdaIn, // serial data pin level
    output logic eeSdaOut, // serial data drive value
    output logic eeSdaOe, // serial data output enable
    output logic loadBusy, // download in progress
    output logic halted, // device not started
    output logic irq // level interrupt
);
    ecl_pkg::ecl_state_e st_r;
    logic [7:0] regFile [0:`ECL_NREG-1];
    logic sdaMeta_r, sdaSync_r;
    logic [15:0] divCnt_r;
    logic [1:0] q_r;
    logic [2:0] bitCnt_r;
    logic [1:0] txIdx_r;
    logic [7:0] txShift_r, rxShift_r, byteIdx_r, pendCtrl_r, regRdData_r;
    logic [31:0] crc_r, crcStore_r;
    logic scl_r, sdaLow_r, ackBit_r, absent_r, boot_r;
    logic eePresent_r, crcOk_r;
    logic [2:0] stat_r, mask_r;
    logic tick, busy, hostWr, trig, byteDone, crcGood;
    logic finishOk, restore, absentEv, crcFailEv;
    logic [2:0] events;
    logic [7:0] sioByte, ctrlByte;

    function automatic logic [31:0] crcByte(input logic [31:0] c,
                                            input logic [7:0] d);
        logic [31:0] r;
        r = c;
        // reflected form, data bits taken low first as in a frame
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? (r >> 1) ^ `ECL_CRC_POLY_REF : r >> 1;
        end
        return r;
    endfunction

    function automatic logic [7:0] dflt(input int a);
        logic [7:0] v;
        v = `ECL_DFLT_BYTE;
        if (a == int'(`ECL_CTRL_ADDR)) begin
            v = `ECL_CTRL_DFLT;
        end else if (a == int'(`ECL_SIO_ADDR)) begin
            v = `ECL_SIO_DFLT;
        end
        return v;
    endfunction

    function automatic logic [7:0] header(input logic [1:0] idx);
        logic [7:0] h;
        h = {`ECL_DEV_TYPE, `ECL_CHIP_ADDR, 1'b0};
        if (idx == 2'h1) begin
            h = 8'h00;
        end else if (idx == 2'h2) begin
            h = {`ECL_DEV_TYPE, `ECL_CHIP_ADDR, 1'b1};
        end
        return h;
    endfunction

    assign busy = (st_r != ecl_pkg::ST_IDLE);
    assign tick = busy && (divCnt_r == 16'(QUARTER_CYCLES - 1));
    assign hostWr = regWr && !busy;
    assign trig = hostWr && (regAddr == `ECL_CTRL_ADDR) &&
                  (regWrData[`ECL_CTRL_LOAD_BIT] ||
                   regWrData[`ECL_CTRL_RESET_BIT]);
    assign byteDone = tick && (st_r == ecl_pkg::ST_RXBIT) &&
                      (q_r == 2'h3) && (bitCnt_r == 3'h7);
    assign crcGood = (crcStore_r == ~crc_r);
    assign finishOk = (st_r == ecl_pkg::ST_FINISH) && crcGood;
    assign crcFailEv = (st_r == ecl_pkg::ST_FINISH) && !crcGood;
    assign absentEv = ((st_r == ecl_pkg::ST_PRES) && tick && !sdaSync_r) ||
                      ((st_r == ecl_pkg::ST_STO) && tick && (q_r == 2'h3) &&
                       absent_r);
    assign restore = crcFailEv || absentEv;
    assign events = {absentEv, crcFailEv, finishOk};
    assign ctrlByte = regFile[`ECL_CTRL_ADDR];
    assign sioByte = regFile[`ECL_SIO_ADDR];

    // pin synchroniser
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdaMeta_r <= 1'b1;
            sdaSync_r <= 1'b1;
        end else if (clkEn) begin
            sdaMeta_r <= eeSdaIn;
            sdaSync_r <= sdaMeta_r;
        end
    end

    // quarter-bit divider for the serial clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_r <= 16'h0000;
        end else if (clkEn) begin
            if (!busy || tick) begin
                divCnt_r <= 16'h0000;
            end else begin
                divCnt_r <= divCnt_r + 16'h0001;
            end
        end
    end

    // download sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ecl_pkg::ST_IDLE;
            q_r <= 2'h0;
            bitCnt_r <= 3'h0;
            txIdx_r <= 2'h0;
            txShift_r <= 8'h00;
            rxShift_r <= 8'h00;
            byteIdx_r <= 8'h00;
            pendCtrl_r <= 8'h00;
            crc_r <= `ECL_CRC_INIT;
            crcStore_r <= 32'h00000000;
            scl_r <= 1'b1;
            sdaLow_r <= 1'b0;
            ackBit_r <= 1'b1;
            absent_r <= 1'b0;
            boot_r <= 1'b1;
        end else if (clkEn) begin
            if (st_r == ecl_pkg::ST_IDLE) begin
                if (boot_r || trig) begin
                    st_r <= ecl_pkg::ST_PRES;
                    boot_r <= 1'b0;
                    q_r <= 2'h0;
                    txIdx_r <= 2'h0;
                    byteIdx_r <= 8'h00;
                    crc_r <= `ECL_CRC_INIT;
                    absent_r <= 1'b0;
                    scl_r <= 1'b1;
                    sdaLow_r <= 1'b0;
                end
            end else if (st_r == ecl_pkg::ST_FINISH) begin
                st_r <= ecl_pkg::ST_IDLE;
            end else if (tick) begin
                q_r <= q_r + 2'h1;
                unique case (st_r)
                    ecl_pkg::ST_PRES: begin
                        q_r <= 2'h0;
                        st_r <= sdaSync_r ? ecl_pkg::ST_STA
                                          : ecl_pkg::ST_IDLE;
                    end
                    ecl_pkg::ST_STA: begin
                        unique case (q_r)
                            2'h0: sdaLow_r <= 1'b0;
                            2'h1: scl_r <= 1'b1;
                            2'h2: sdaLow_r <= 1'b1;
                            2'h3: begin
                                scl_r <= 1'b0;
                                bitCnt_r <= 3'h0;
                                txShift_r <= header(txIdx_r);
                                st_r <= ecl_pkg::ST_TXBIT;
                            end
                        endcase
                    end
                    ecl_pkg::ST_TXBIT: begin
                        unique case (q_r)
                            2'h0: sdaLow_r <= ~txShift_r[7];
                            2'h1: scl_r <= 1'b1;
                            2'h2: ;
                            2'h3: begin
                                scl_r <= 1'b0;
                                txShift_r <= {txShift_r[6:0], 1'b0};
                                bitCnt_r <= bitCnt_r + 3'h1;
                                if (bitCnt_r == 3'h7) begin
                                    st_r <= ecl_pkg::ST_TXACK;
                                end
                            end
                        endcase
                    end
                    ecl_pkg::ST_TXACK: begin
                        unique case (q_r)
                            2'h0: sdaLow_r <= 1'b0;
                            2'h1: scl_r <= 1'b1;
                            2'h2: ackBit_r <= sdaSync_r;
                            2'h3: begin
                                scl_r <= 1'b0;
                                bitCnt_r <= 3'h0;
                                if (ackBit_r) begin
                                    absent_r <= 1'b1;
                                    st_r <= ecl_pkg::ST_STO;
                                end else if (txIdx_r == 2'h0) begin
                                    txIdx_r <= 2'h1;
                                    txShift_r <= header(2'h1);
                                    st_r <= ecl_pkg::ST_TXBIT;
                                end else if (txIdx_r == 2'h1) begin
                                    txIdx_r <= 2'h2;
                                    st_r <= ecl_pkg::ST_STA;
                                end else begin
                                    st_r <= ecl_pkg::ST_RXBIT;
                                end
                            end
                        endcase
                    end
                    ecl_pkg::ST_RXBIT: begin
                        unique case (q_r)
                            2'h0: sdaLow_r <= 1'b0;
                            2'h1: scl_r <= 1'b1;
                            2'h2: rxShift_r <= {rxShift_r[6:0], sdaSync_r};
                            2'h3: begin
                                scl_r <= 1'b0;
                                bitCnt_r <= bitCnt_r + 3'h1;
                                if (bitCnt_r == 3'h7) begin
                                    st_r <= ecl_pkg::ST_RXACK;
                                    if (byteIdx_r <= `ECL_CTRL_ADDR) begin
                                        crc_r <= crcByte(crc_r, rxShift_r);
                                    end else begin
                                        crcStore_r <= {crcStore_r[23:0],
                                                       rxShift_r};
                                    end
                                    if (byteIdx_r == `ECL_CTRL_ADDR) begin
                                        pendCtrl_r <= rxShift_r;
                                    end
                                end
                            end
                        endcase
                    end
                    ecl_pkg::ST_RXACK: begin
                        unique case (q_r)
                            2'h0: sdaLow_r <= (byteIdx_r != `ECL_LAST_ADDR);
                            2'h1: scl_r <= 1'b1;
                            2'h2: ;
                            2'h3: begin
                                scl_r <= 1'b0;
                                bitCnt_r <= 3'h0;
                                if (byteIdx_r == `ECL_LAST_ADDR) begin
                                    st_r <= ecl_pkg::ST_STO;
                                end else begin
                                    byteIdx_r <= byteIdx_r + 8'h01;
                                    st_r <= ecl_pkg::ST_RXBIT;
                                end
                            end
                        endcase
                    end
                    ecl_pkg::ST_STO: begin
                        unique case (q_r)
                            2'h0: sdaLow_r <= 1'b1;
                            2'h1: scl_r <= 1'b1;
                            2'h2: sdaLow_r <= 1'b0;
                            2'h3: st_r <= absent_r ? ecl_pkg::ST_IDLE
                                                   : ecl_pkg::ST_FINISH;
                        endcase
                    end
                    default: st_r <= ecl_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // register image
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `ECL_NREG; i++) begin
                regFile[i] <= dflt(i);
            end
        end else if (clkEn) begin
            if (restore) begin
                for (int i = 0; i < `ECL_NREG; i++) begin
                    regFile[i] <= dflt(i);
                end
            end else begin
                if (byteDone && (byteIdx_r < `ECL_CTRL_ADDR)) begin
                    regFile[byteIdx_r] <= rxShift_r;
                end
                if (finishOk) begin
                    regFile[`ECL_CTRL_ADDR] <= pendCtrl_r &
                        ~(8'h01 << `ECL_CTRL_LOAD_BIT) &
                        ~(8'h01 << `ECL_CTRL_RESET_BIT);
                end
                if (hostWr && (regAddr < `ECL_CTRL_ADDR)) begin
                    regFile[regAddr] <= regWrData;
                end else if (hostWr && (regAddr == `ECL_CTRL_ADDR)) begin
                    // start bit resumes a halted device
                    regFile[regAddr] <= regWrData &
                        ~(8'h01 << `ECL_CTRL_RESET_BIT);
                end
            end
        end
    end

    // sticky events, mask and result flags
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= 3'h0;
            mask_r <= 3'h0;
            eePresent_r <= 1'b0;
            crcOk_r <= 1'b0;
        end else if (clkEn) begin
            if (hostWr && (regAddr == `ECL_STAT_ADDR)) begin
                stat_r <= (stat_r & ~regWrData[2:0]) | events;
            end else begin
                stat_r <= stat_r | events;
            end
            if (hostWr && (regAddr == `ECL_MASK_ADDR)) begin
                mask_r <= regWrData[2:0];
            end
            if (absentEv) begin
                eePresent_r <= 1'b0;
                crcOk_r <= 1'b0;
            end else if (st_r == ecl_pkg::ST_FINISH) begin
                eePresent_r <= 1'b1;
                crcOk_r <= crcGood;
            end
        end
    end

    // read port
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData_r <= 8'h00;
        end else if (clkEn) begin
            regRdData_r <= 8'h00;
            if (regRd && !busy) begin
                if (regAddr == `ECL_SIO_ADDR) begin
                    regRdData_r <= sioByte;
                    regRdData_r[`ECL_SIO_DATA_BIT] <= sdaSync_r;
                end else if (regAddr <= `ECL_CTRL_ADDR) begin
                    regRdData_r <= regFile[regAddr];
                end else if (regAddr == `ECL_STAT_ADDR) begin
                    regRdData_r <= {5'h00, stat_r};
                end else if (regAddr == `ECL_MASK_ADDR) begin
                    regRdData_r <= {5'h00, mask_r};
                end else if (regAddr == `ECL_STATE_ADDR) begin
                    regRdData_r <= {5'h00, crcOk_r, eePresent_r, busy};
                end
            end
        end
    end

    assign regRdData = regRdData_r;
    // host owns the pins between downloads
    assign eeSclOut = busy ? scl_r : sioByte[`ECL_SIO_CLK_BIT];
    assign eeSdaOut = 1'b0;
    assign eeSdaOe = busy ? sdaLow_r : ~sioByte[`ECL_SIO_DATA_BIT];
    assign loadBusy = busy;
    assign halted = busy || !ctrlByte[`ECL_CTRL_START_BIT];
    assign irq = |(stat_r & mask_r);
endmodule // ecl_loader
`default_nettype wire

// ===== bench/ecl_loader_props.sv
// Purpose: concurrent checks on the loader's ports
// Assumes: bound to ecl_loader, one clock domain on ref_clk
// Notes: image contents and status bits are judged by the bench
`timescale 1ns/10ps
`default_nettype none
module ecl_loader_props (
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic clkEn, // clock enable
    input wire logic [7:0] regAddr, // register address
    input wire logic [7:0] regWrData, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    input wire logic [7:0] regRdData, // read data
    input wire logic eeSclOut, // serial clock
    input wire logic eeSdaIn, // data pin level
    input wire logic eeSdaOut, // data drive value
    input wire logic eeSdaOe, // data output enable
    input wire logic loadBusy, // download running
    input wire logic halted, // not started
    input wire logic irq // interrupt
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    reset_load_a: assert property (
        !$past(rst_n, 2) && $past(rst_n) |-> loadBusy)
        else $error("no download after reset release");
    busy_read_a: assert property (
        $past(regRd && loadBusy) |-> regRdData == 8'h00)
        else $error("read answered during download");
    load_trigger_a: assert property (
        $rose(loadBusy) |-> !$past(rst_n, 2) || $past(regWr && clkEn
        && regAddr == 8'hC3 && (regWrData[1] || regWrData[2])))
        else $error("download started without a request");
    halt_hold_a: assert property (
        $fell(halted) |-> $past(regWr) || $past(loadBusy))
        else $error("halt released without cause");
    start_run_a: assert property (
        $past(regWr && clkEn && !loadBusy && regAddr == 8'hC3
        && regWrData[2:0] == 3'b001) |-> !halted)
        else $error("start bit did not release halt");
    bit_bang_a: assert property (
        $past(regWr && clkEn && !loadBusy && regAddr == 8'hA1)
        |-> eeSclOut == $past(regWrData[0])
        && eeSdaOe == !$past(regWrData[1]))
        else $error("serial pins do not follow host bits");
    scl_quiet_a: assert property (
        !loadBusy && !$past(loadBusy) && !$past(regWr)
        |-> $stable(eeSclOut))
        else $error("serial clock moved while idle");
    irq_rise_a: assert property (
        $rose(irq) |-> $past(regWr) || $past(loadBusy)
        || $past(loadBusy, 2))
        else $error("interrupt rose without cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(regWr))
        else $error("interrupt fell without a write");
endmodule // ecl_loader_props
`default_nettype wire

// ===== bench/ecl_eeprom_model.sv
// Purpose: behavioural two-wire serial EEPROM for the loader bench
// Assumes: data line has a pullup, clk far faster than serial clock
// Notes: en low stops all acknowledges; seen regs keep last headers
`timescale 1ns/10ps
`default_nettype none
module ecl_eeprom_model (
    input wire logic clk, // sampling clock
    input wire logic en, // answers when high
    input wire logic scl, // serial clock from the loader
    input wire logic sda, // resolved data line
    output logic pullLow // pulls the data line low
);
    logic [7:0] mem [256];
    logic [7:0] shiftR, ptr, seenWr, seenRd, seenWa;
    logic [3:0] bitCnt;
    logic [1:0] hdr;
    logic sclQ = 1'b1, sdaQ = 1'b1, active = 1'b0, rdMode, drv = 1'b0;
    assign pullLow = en && drv;
    always @(posedge clk) begin
        sclQ <= scl;
        sdaQ <= sda;
        if (scl && sclQ && sdaQ && !sda) begin
            active <= 1'b1;
            hdr <= 2'd0;
            bitCnt <= 4'd0;
            rdMode <= 1'b0;
            drv <= 1'b0;
        end else if (scl && sclQ && !sdaQ && sda) begin
            active <= 1'b0;
            drv <= 1'b0;
        end else if (active && scl && !sclQ) begin
            bitCnt <= (bitCnt == 4'd8) ? 4'd0 : bitCnt + 4'd1;
            if (bitCnt != 4'd8)
                shiftR <= {shiftR[6:0], sda};
            if (bitCnt == 4'd8 && rdMode && sda)
                active <= 1'b0;
        end else if (active && !scl && sclQ) begin
            if (bitCnt == 4'd8 && rdMode) begin
                drv <= 1'b0;
                ptr <= ptr + 8'd1;
            end else if (bitCnt == 4'd8) begin
                drv <= (hdr != 2'd0) || (shiftR[7:1] == 7'b1010000);
                hdr <= hdr + 2'd1;
                rdMode <= (hdr == 2'd0) && shiftR[0];
                if (hdr == 2'd0 && shiftR[0])
                    seenRd <= shiftR;
                if (hdr == 2'd0 && !shiftR[0])
                    seenWr <= shiftR;
                if (hdr == 2'd1)
                    seenWa <= shiftR;
                if (hdr == 2'd1)
                    ptr <= shiftR;
            end else begin
                drv <= rdMode && !mem[ptr][3'd7 - bitCnt[2:0]];
            end
        end
    end
endmodule // ecl_eeprom_model
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: self-checking bench for the EEPROM configuration loader
// Assumes: serial model on the data line, pullup resolved here
// Notes: short quarter-bit count keeps a download near 15k cycles
`timescale 1ns/10ps
`default_nettype none
`include "ecl_regs.svh"
module tb_top;
    logic ref_clk, rst_n, clkEn, regWr, regRd, noEe, eeOn, eeSdaIn, memLow;
    logic eeSclOut, eeSdaOut, eeSdaOe, loadBusy, halted, irq;
    logic [7:0] regAddr, regWrData, regRdData, rd;
    int bad_count = 0, cmp_count = 0, cycles = 0, sclFalls = 0;
    ecl_loader #(.QUARTER_CYCLES(2)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .eeSclOut(eeSclOut), .eeSdaIn(eeSdaIn), .eeSdaOut(eeSdaOut),
        .eeSdaOe(eeSdaOe), .loadBusy(loadBusy), .halted(halted), .irq(irq));
    ecl_eeprom_model EE (.clk(ref_clk), .en(eeOn), .scl(eeSclOut),
        .sda(eeSdaIn), .pullLow(memLow));
    assign eeSdaIn = !(noEe || eeSdaOe || memLow);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(negedge eeSclOut) sclFalls++;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rdr(input logic [7:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        rd = regRdData;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (loadBusy !== 1'b0 && n < 20000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        #1;
        check({7'h00, loadBusy}, 8'h00);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
    endtask
    // image with a reflected CRC-32; bad flips one stored bit
    task automatic fill(input logic bad);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < 256; i++) begin
            EE.mem[i] = (i == 'hA1) ? 8'h03 : (i == 'hC3) ? 8'h05
                      : 8'(i * 37 + 11);
            if (i < 'hC4) begin
                c = c ^ {24'h000000, EE.mem[i]};
                for (int b = 0; b < 8; b++)
                    c = c[0] ? (c >> 1) ^ `ECL_CRC_POLY_REF : c >> 1;
            end
        end
        c = ~c ^ {31'h0, bad};
        {EE.mem['hC4], EE.mem['hC5], EE.mem['hC6], EE.mem['hC7]} = c;
    endtask
    task automatic t_absent();
        noEe <= 1'b1;
        do_reset();
        check({7'h00, loadBusy}, 8'h01);
        wait_idle();
        rdr(`ECL_STAT_ADDR);
        check(rd, 8'h04);
        rdr(`ECL_STATE_ADDR);
        check(rd, 8'h00);
        check({7'h00, halted}, 8'h01);
        check(sclFalls[7:0], 8'h00);
        noEe <= 1'b0;
    endtask
    task automatic t_load_ok();
        fill(1'b0);
        do_reset();
        repeat (300) @(posedge ref_clk);
        #1;
        wr(`ECL_MASK_ADDR, 8'h07);
        wr(`ECL_CTRL_ADDR, 8'h04);
        rdr(`ECL_SIO_ADDR);
        check(rd, 8'h00);
        wait_idle();
        repeat (20) @(posedge ref_clk);
        #1;
        check({7'h00, irq}, 8'h00);
        check({7'h00, loadBusy}, 8'h00);
        for (int i = 0; i < 'hC3; i++) begin
            rdr(i[7:0]);
            if (i != 'hA1)
                check(rd, EE.mem[i]);
        end
        rdr(`ECL_CTRL_ADDR);
        check(rd, 8'h01);
        check({7'h00, halted}, 8'h00);
        rdr(`ECL_STATE_ADDR);
        check(rd, 8'h06);
        rdr(`ECL_STAT_ADDR);
        check(rd, 8'h01);
        check(EE.seenWr, 8'hA0);
        check(EE.seenRd, 8'hA1);
        check(EE.seenWa, 8'h00);
    endtask
    task automatic t_irq();
        wr(`ECL_MASK_ADDR, 8'h01);
        check({7'h00, irq}, 8'h01);
        wr(`ECL_MASK_ADDR, 8'h00);
        check({7'h00, irq}, 8'h00);
        wr(`ECL_MASK_ADDR, 8'h01);
        wr(`ECL_STAT_ADDR, 8'h01);
        check({7'h00, irq}, 8'h00);
        rdr(`ECL_STAT_ADDR);
        check(rd, 8'h00);
    endtask
    task automatic t_bitbang();
        wr(`ECL_SIO_ADDR, 8'h01);
        check({6'h00, eeSclOut, eeSdaOe}, 8'h03);
        check({7'h00, eeSdaOut}, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        rdr(`ECL_SIO_ADDR);
        check(rd & 8'h03, 8'h01);
        wr(`ECL_SIO_ADDR, 8'h02);
        clkEn <= 1'b0;
        wr(`ECL_SIO_ADDR, 8'h03);
        clkEn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        rdr(`ECL_SIO_ADDR);
        check(rd & 8'h03, 8'h02);
        wr(`ECL_SIO_ADDR, 8'h03);
    endtask
    task automatic t_crc_fail();
        fill(1'b1);
        wr(`ECL_CTRL_ADDR, 8'h04);
        check({7'h00, loadBusy}, 8'h01);
        wait_idle();
        for (int i = 0; i <= 'hC3; i++) begin
            rdr(i[7:0]);
            check(rd, (i == 'hA1) ? 8'h03 : 8'h00);
        end
        check({7'h00, halted}, 8'h01);
        rdr(`ECL_STAT_ADDR);
        check(rd, 8'h02);
        wr(`ECL_CTRL_ADDR, 8'h01);
        check({7'h00, halted}, 8'h00);
    endtask
    task automatic t_nack();
        eeOn <= 1'b0;
        wr(`ECL_CTRL_ADDR, 8'h02);
        wait_idle();
        rdr(`ECL_STAT_ADDR);
        check(rd, 8'h06);
        check({7'h00, halted}, 8'h01);
        eeOn <= 1'b1;
    endtask
    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        noEe = 1'b0;
        eeOn = 1'b1;
        t_absent();
        t_load_ok();
        t_irq();
        t_bitbang();
        t_crc_fail();
        t_nack();
        stop_test();
    end
endmodule // tb_top
bind ecl_loader ecl_loader_props CHK (.ref_clk(ref_clk), .rst_n(rst_n),
    .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .eeSclOut(eeSclOut),
    .eeSdaIn(eeSdaIn), .eeSdaOut(eeSdaOut), .eeSdaOe(eeSdaOe),
    .loadBusy(loadBusy), .halted(halted), .irq(irq));
`default_nettype wire
